// [rtl/sshp_cfg.svh]
// Constants for the SPI slave host port: opcodes, field positions, limits
`ifndef SSHP_CFG_SVH
`define SSHP_CFG_SVH
`define SSHP_OP_REG_RD      2'h0
`define SSHP_OP_REG_WR      2'h1
`define SSHP_OP_RXQ_RD      2'h2
`define SSHP_OP_TXQ_WR      2'h3
`define SSHP_OP_MSB         7
`define SSHP_OP_LSB         6
`define SSHP_BE_MSB         5
`define SSHP_BE_LSB         2
`define SSHP_ADDR_HI_MSB    1
`define SSHP_ADDR_LO_MSB    7
`define SSHP_ADDR_LO_LSB    4
`define SSHP_RXQ_MAX_BYTES  12288
`define SSHP_TXQ_MAX_BYTES  6144
`define SSHP_CLK_DIV        4
`define SSHP_QCMD_DMA_BIT   3
`endif

// [rtl/sshp_if.sv]
// Four-wire link between the SPI master and the slave port
`timescale 1ns/100ps
`default_nettype none
interface sshp_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  modport slave  (input sclk, input cs_n, input sdi, output sdo);
  modport master (output sclk, output cs_n, output sdi, input sdo);
endinterface
`default_nettype wire

// [rtl/sshp_master.sv]
// Host end of the SPI slave host port: frames commands and shifts data
`include "sshp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sshp_master
  import sshp_pkg::*;
(
  input  wire logic        clk_i,      // System clock
  input  wire logic        nrst_i,     // Async reset, active low
  sshp_if.master           spi,        // Serial link
  input  wire logic        start_i,    // Begin a transaction
  input  wire sshp_op_t    op_i,       // Operation code
  input  wire sshp_be_t    be_i,       // Byte lanes for register access
  input  wire sshp_addr_t  addr_i,     // Dword address
  input  wire logic [13:0] len_i,      // Queue burst length in bytes
  input  wire logic [31:0] wdata_i,    // Register write data
  input  wire logic [7:0]  qdata_i,    // Next transmit queue byte
  output logic             qtake_o,    // Queue byte consumed
  output logic [7:0]       rbyte_o,    // Last received byte
  output logic             rvalid_o,   // Received byte strobe
  output logic             busy_o      // Transaction in progress
);
  logic [1:0]  sdo_s;
  logic [1:0]  div;
  logic [7:0]  sh;
  logic [2:0]  bitcnt;
  logic [13:0] left;
  logic [1:0]  lane;
  logic [3:0]  be_rest;
  logic        ncmd;
  sshp_op_t    op;
  logic [31:0] wd;

  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      sdo_s <= 2'h0;
    else
      sdo_s <= {sdo_s[0], spi.sdo};

  wire tick  = (div == 2'(`SSHP_CLK_DIV - 1));
  wire [3:0] cnt_be = {3'h0, be_i[0]} + {3'h0, be_i[1]} + {3'h0, be_i[2]} + {3'h0, be_i[3]};
  wire [7:0] cmd0 = op_i[1] ? {op_i, 6'h00} : {op_i, be_i, addr_i[5:4]};

  function automatic logic [1:0] low_lane(input logic [3:0] be);
    low_lane = be[0] ? 2'h0 : be[1] ? 2'h1 : be[2] ? 2'h2 : 2'h3;
  endfunction

  // Clock low phase then high phase, each one full divider period; idle low
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      div <= 2'h0;
      spi.sclk <= 1'b0;
      spi.cs_n <= 1'b1;
      spi.sdi <= 1'b0;
      sh <= 8'h00;
      bitcnt <= 3'h0;
      left <= 14'h0;
      lane <= 2'h0;
      be_rest <= 4'h0;
      ncmd <= 1'b0;
      op <= 2'h0;
      wd <= 32'h0;
      qtake_o <= 1'b0;
      rbyte_o <= 8'h00;
      rvalid_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      qtake_o <= 1'b0;
      rvalid_o <= 1'b0;
      div <= busy_o ? div + 2'h1 : 2'h0;
      if (!busy_o)
      begin
        if (start_i)
        begin
          busy_o <= 1'b1;
          spi.cs_n <= 1'b0;
          op <= op_i;
          wd <= wdata_i;
          be_rest <= be_i;
          lane <= low_lane(be_i);
          sh <= cmd0;
          spi.sdi <= cmd0[7];
          bitcnt <= 3'h0;
          ncmd <= ~op_i[1];
          left <= op_i[1] ? ((len_i > 14'(`SSHP_RXQ_MAX_BYTES)) ? 14'(`SSHP_RXQ_MAX_BYTES)
                                                              : len_i) : {10'h0, cnt_be};
        end
      end
      else if (tick)
      begin
        spi.sclk <= ~spi.sclk;
        if (!spi.sclk)
          sh <= {sh[6:0], sdo_s[1]};
        else
        begin
          bitcnt <= bitcnt + 3'h1;
          spi.sdi <= sh[7];
          if (bitcnt == 3'h7)
          begin
            if (ncmd)
            begin
              ncmd <= 1'b0;
              sh <= {addr_i[3:0], 4'h0};
              spi.sdi <= addr_i[3];
            end
            else if (left == 14'h0)
            begin
              spi.cs_n <= 1'b1;
              spi.sclk <= 1'b0;
              busy_o <= 1'b0;
            end
            else
            begin
              rbyte_o <= sh;
              rvalid_o <= !op[0];
              left <= left - 14'h1;
              sh <= op[1] ? qdata_i : wd[8*lane +: 8];
              spi.sdi <= op[1] ? qdata_i[7] : wd[8*lane + 7];
              qtake_o <= op[1];
              be_rest[lane] <= 1'b0;
              lane <= low_lane(be_rest & ~(4'h1 << lane));
            end
          end
        end
      end
    end
endmodule // sshp_master
`default_nettype wire

// [rtl/sshp_pkg.sv]
// Types shared by both ends of the SPI slave host port, plus the command phases used by the slave end only
package sshp_pkg;
  typedef logic [1:0] sshp_op_t;
  typedef logic [5:0] sshp_addr_t;
  typedef logic [3:0] sshp_be_t;
  typedef enum logic [1:0] {SSHP_CMD0, SSHP_CMD1, SSHP_DATA} sshp_phase_e;
endpackage

// [rtl/sshp_slave.sv]
// Device end of the SPI slave host port: command decode, register and queue access
`include "sshp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sshp_slave
  import sshp_pkg::*;
(
  input  wire logic        clk_i,        // System clock
  input  wire logic        nrst_i,       // Async reset, active low
  sshp_if.slave            spi,          // Serial link
  output logic             reg_wr_o,     // Register write strobe
  output logic             reg_rd_o,     // Register read strobe
  output sshp_addr_t       reg_addr_o,   // Dword address
  output sshp_be_t         reg_be_o,     // Byte lanes to write
  output logic [31:0]      reg_wdata_o,  // Write data
  input  wire logic [31:0] reg_rdata_i,  // Read data, valid after reg_rd_o
  output logic             txq_valid_o,  // Transmit queue byte strobe
  output logic [7:0]       txq_data_o,   // Transmit queue byte
  output logic             rxq_pop_o,    // Receive queue byte request
  input  wire logic [7:0]  rxq_data_i,   // Receive queue byte, valid after pop
  output logic             busy_o        // Transaction in progress
);
  logic [1:0]  sclk_s;
  logic [1:0]  cs_s;
  logic [1:0]  sdi_s;
  logic        sclk_d;
  logic        cs_d;
  sshp_phase_e phase;
  logic [2:0]  bitcnt;
  logic [7:0]  shin;
  logic [7:0]  shout;
  sshp_op_t    op;
  logic [1:0]  lane;
  logic [13:0] bytes;
  logic        rd_pend;
  logic        pop_pend;
  logic [31:0] rbuf;

  // Pins cross into clk_i domain through two flops
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      sclk_s <= 2'h0;
      cs_s   <= 2'h3;
      sdi_s  <= 2'h0;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end
    else
    begin
      sclk_s <= {sclk_s[0], spi.sclk};
      cs_s   <= {cs_s[0], spi.cs_n};
      sdi_s  <= {sdi_s[0], spi.sdi};
      sclk_d <= sclk_s[1];
      cs_d   <= cs_s[1];
    end

  wire       sclk_rise = sclk_s[1] & ~sclk_d & ~cs_s[1];
  wire       cs_fall   = ~cs_s[1] & cs_d;
  wire       cs_rise   = cs_s[1] & ~cs_d;
  wire [7:0] byte_in   = {shin[6:0], sdi_s[1]};
  wire       byte_done = sclk_rise && bitcnt == 3'h7;
  wire       is_reg    = ~byte_in[`SSHP_OP_MSB];
  wire [1:0] new_op    = byte_in[`SSHP_OP_MSB:`SSHP_OP_LSB];
  wire [13:0] qlimit   = (op == `SSHP_OP_RXQ_RD) ? 14'(`SSHP_RXQ_MAX_BYTES)
                                                 : 14'(`SSHP_TXQ_MAX_BYTES);

  // Next enabled lane at or after l; 3'h4 when none
  function automatic logic [2:0] next_lane(input logic [3:0] be, input logic [2:0] l);
    logic [2:0] r;
    r = 3'h4;
    for (int i = 3; i >= 0; i--)
      if (be[i] && 3'(i) >= l)
        r = 3'(i);
    return r;
  endfunction

  wire [2:0] first_lane = next_lane(reg_be_o, 3'h0);
  wire [2:0] after_lane = next_lane(reg_be_o, {1'b0, lane} + 3'h1);

  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      phase       <= SSHP_CMD0;
      bitcnt      <= 3'h0;
      shin        <= 8'h00;
      op          <= 2'h0;
      lane        <= 2'h0;
      bytes       <= 14'h0;
      reg_addr_o  <= 6'h00;
      reg_be_o    <= 4'h0;
      reg_wdata_o <= 32'h0;
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
      txq_valid_o <= 1'b0;
      txq_data_o  <= 8'h00;
      rxq_pop_o   <= 1'b0;
      busy_o      <= 1'b0;
    end
    else
    begin
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
      txq_valid_o <= 1'b0;
      rxq_pop_o   <= 1'b0;
      if (cs_fall || cs_rise)
      begin
        // Partial commands die here with no strobe issued
        phase  <= SSHP_CMD0;
        bitcnt <= 3'h0;
        busy_o <= cs_fall;
        // Register write commits once, at frame end, with the lanes named in the command
        if (cs_rise && phase == SSHP_DATA && op == `SSHP_OP_REG_WR)
          reg_wr_o <= 1'b1;
      end
      else if (sclk_rise)
      begin
        shin   <= byte_in;
        bitcnt <= bitcnt + 3'h1;
        if (byte_done)
        begin
          unique case (phase)
            SSHP_CMD0:
            begin
              op <= new_op;
              reg_be_o <= byte_in[`SSHP_BE_MSB:`SSHP_BE_LSB];
              reg_addr_o[5:4] <= byte_in[`SSHP_ADDR_HI_MSB:0];
              bytes <= 14'h0;
              phase <= is_reg ? SSHP_CMD1 : SSHP_DATA;
              if (new_op == `SSHP_OP_RXQ_RD)
                rxq_pop_o <= 1'b1;
            end
            SSHP_CMD1:
            begin
              reg_addr_o[3:0] <= byte_in[`SSHP_ADDR_LO_MSB:`SSHP_ADDR_LO_LSB];
              lane  <= first_lane[1:0];
              reg_wdata_o <= 32'h0;
              phase <= SSHP_DATA;
              if (op == `SSHP_OP_REG_RD)
                reg_rd_o <= 1'b1;
            end
            SSHP_DATA:
            begin
              if (op == `SSHP_OP_REG_WR && !after_lane[2] | (after_lane == 3'h4 && bytes < 14'h4)
                  && op == `SSHP_OP_REG_WR)
                reg_wdata_o[8*lane +: 8] <= byte_in;
              if (!after_lane[2])
                lane <= after_lane[1:0];
              if (op[1] && bytes < qlimit)
              begin
                bytes <= bytes + 14'h1;
                if (op == `SSHP_OP_TXQ_WR)
                begin
                  txq_valid_o <= 1'b1;
                  txq_data_o  <= byte_in;
                end
                else
                  rxq_pop_o <= 1'b1;
              end
              else if (!op[1])
                bytes <= bytes + 14'h1;
            end
          endcase
        end
      end
    end

  // Read data loads one cycle after its request
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      rd_pend  <= 1'b0;
      pop_pend <= 1'b0;
      rbuf     <= 32'h0;
    end
    else
    begin
      rd_pend  <= reg_rd_o;
      pop_pend <= rxq_pop_o;
      if (rd_pend)
        rbuf <= reg_rdata_i;
      else if (pop_pend)
        rbuf <= {24'h0, rxq_data_i};
    end

  wire [7:0] out_byte = op[1] ? rbuf[7:0] : rbuf[8*lane +: 8];

  // Output shifts on sclk rise so the master samples it on the next rise
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      shout <= 8'h00;
    else if (cs_fall)
      shout <= 8'h00;
    else if (sclk_rise)
    begin
      if (bitcnt == 3'h0 && phase == SSHP_DATA)
        shout <= {out_byte[6:0], 1'b0};
      else
        shout <= {shout[6:0], 1'b0};
    end

  logic sdo_q;
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      sdo_q <= 1'b0;
    else if (sclk_rise)
      sdo_q <= (bitcnt == 3'h0 && phase == SSHP_DATA) ? out_byte[7] : shout[7];

  assign spi.sdo = sdo_q;
endmodule // sshp_slave
`default_nettype wire

// [verif/spi_slave_host_port_bench.sv]
// Bench joining master and slave ends, plus a bench-driven link for aborts
`include "sshp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module spi_slave_host_port_bench
  import sshp_pkg::*;
;
  typedef struct {sshp_op_t op; sshp_be_t be; sshp_addr_t ad; logic [13:0] len; logic [31:0] wd;} sshp_row_s;
  sshp_row_s rows [7] = '{
    '{`SSHP_OP_REG_WR, 4'h1, 6'h3f, 14'h0, 32'h1122_3344},
    '{`SSHP_OP_REG_WR, 4'ha, 6'h15, 14'h0, 32'hdead_beef},
    '{`SSHP_OP_REG_WR, 4'hf, 6'h00, 14'h0, 32'h0f1e_2d3c},
    '{`SSHP_OP_REG_RD, 4'h8, 6'h2a, 14'h0, 32'h0},
    '{`SSHP_OP_REG_RD, 4'hf, 6'h01, 14'h0, 32'h0},
    '{`SSHP_OP_TXQ_WR, 4'h0, 6'h00, 14'h3, 32'h0},
    '{`SSHP_OP_RXQ_RD, 4'h0, 6'h00, 14'h2, 32'h0}};
  logic        clk_i = 1'b0, nrst_i = 1'b0, start_i = 1'b0;
  sshp_op_t    op_i = 2'h0;
  sshp_be_t    be_i = 4'h0;
  sshp_addr_t  addr_i = 6'h00;
  logic [13:0] len_i = 14'h0;
  logic [31:0] wdata_i = 32'h0, reg_wdata, m;
  logic [7:0]  qdata_i = 8'h00, txexp = 8'h00, rbyte, txq_data;
  logic [5:0]  reg_addr;
  logic [3:0]  reg_be;
  logic        qtake, rvalid, mbusy, sbusy, reg_wr, reg_rd, txq_valid, rxq_pop;
  logic        wr2, rd2, tv2, pop2;
  int          checks = 0, miscompares = 0, nwr = 0, nrd = 0, ntx = 0, npop = 0, n2 = 0;
  int          w0, r0, x0, p0;
  sshp_if link();
  sshp_if link2();
  sshp_master sshp_master_inst (.clk_i(clk_i), .nrst_i(nrst_i), .spi(link), .start_i(start_i),
    .op_i(op_i), .be_i(be_i), .addr_i(addr_i), .len_i(len_i), .wdata_i(wdata_i),
    .qdata_i(qdata_i), .qtake_o(qtake), .rbyte_o(rbyte), .rvalid_o(rvalid), .busy_o(mbusy));
  sshp_slave sshp_slave_inst (.clk_i(clk_i), .nrst_i(nrst_i), .spi(link), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_be_o(reg_be), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(32'hc3a5_5a3c), .txq_valid_o(txq_valid), .txq_data_o(txq_data),
    .rxq_pop_o(rxq_pop), .rxq_data_i(8'h5a), .busy_o(sbusy));
  sshp_slave sshp_slave_inst2 (.clk_i(clk_i), .nrst_i(nrst_i), .spi(link2), .reg_wr_o(wr2),
    .reg_rd_o(rd2), .reg_addr_o(), .reg_be_o(), .reg_wdata_o(), .reg_rdata_i(32'h0),
    .txq_valid_o(tv2), .txq_data_o(), .rxq_pop_o(pop2), .rxq_data_i(8'h00), .busy_o());
  sshp_monitor sshp_monitor_inst (.clk_i(clk_i), .nrst_i(nrst_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo));
  initial forever #25 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    if (reg_wr === 1'b1) nwr++;
    if (reg_rd === 1'b1) nrd++;
    if (rxq_pop === 1'b1) npop++;
    // Strobes are unknown until the first clocked reset, so count only once running
    if (nrst_i && (wr2 | rd2 | tv2 | pop2) !== 1'b0) n2++;
    if (txq_valid === 1'b1)
    begin
      ntx++;
      check(32'(txq_data), 32'(txexp));
      txexp++;
    end
  end
  // Next queue byte appears only once the master has consumed the last one
  always @(negedge clk_i)
    if (qtake === 1'b1) qdata_i <= qdata_i + 8'h01;
  task automatic run(input sshp_row_s r);
    int t;
    @(negedge clk_i);
    op_i = r.op;
    be_i = r.be;
    addr_i = r.ad;
    len_i = r.len;
    wdata_i = r.wd;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    t = 0;
    while ((t < 16 || mbusy !== 1'b0 || sbusy !== 1'b0) && t < 20000)
    begin
      @(negedge clk_i);
      t++;
    end
    repeat (4) @(negedge clk_i);
  endtask
  // Partial frame on the bench-driven link; the clock only runs inside it
  task automatic abort_frame(input logic [15:0] w, input int n);
    link2.cs_n = 1'b0;
    for (int b = 15; b > 15 - n; b--)
    begin
      link2.sdi = w[b];
      repeat (4) @(negedge clk_i);
      link2.sclk = 1'b1;
      repeat (4) @(negedge clk_i);
      link2.sclk = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    link2.cs_n = 1'b1;
    repeat (16) @(negedge clk_i);
  endtask
  initial
  begin
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.sdi = 1'b0;
    repeat (4) @(negedge clk_i);
    check(32'(link.cs_n), 32'h1);
    check(32'(link.sclk), 32'h0);
    check(32'({reg_wr, reg_rd, txq_valid, rxq_pop, sbusy, mbusy}), 32'h0);
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    $display("reset test done");
    foreach (rows[i])
    begin
      w0 = nwr;
      r0 = nrd;
      x0 = ntx;
      p0 = npop;
      m = {{8{rows[i].be[3]}}, {8{rows[i].be[2]}}, {8{rows[i].be[1]}}, {8{rows[i].be[0]}}};
      run(rows[i]);
      check(32'(nwr - w0), 32'(rows[i].op == `SSHP_OP_REG_WR));
      check(32'(nrd - r0), 32'(rows[i].op == `SSHP_OP_REG_RD));
      check(32'(ntx - x0), rows[i].op == `SSHP_OP_TXQ_WR ? 32'(rows[i].len) : 32'h0);
      // Receive side fetches one byte ahead of the data phase
      check(32'(npop - p0), rows[i].op == `SSHP_OP_RXQ_RD ? 32'(rows[i].len) + 32'h1 : 32'h0);
      if (!rows[i].op[1])
        check(32'(reg_addr), 32'(rows[i].ad));
      if (rows[i].op == `SSHP_OP_REG_WR)
      begin
        check(32'(reg_be), 32'(rows[i].be));
        check(reg_wdata & m, rows[i].wd & m);
      end
      $display("row %0d done", i);
    end
    abort_frame(16'h7c00, 12);
    abort_frame(16'hc000, 5);
    check(32'(n2), 32'h0);
    $display("abort test done");
    results();
  end
  initial
  begin
    #(1_000_000);
    miscompares++;
    results();
  end
endmodule // spi_slave_host_port_bench
`default_nettype wire

// [verif/sshp_monitor.sv]
// Wire-level checks on the serial link between the two port ends
`timescale 1ns/100ps
`default_nettype none
module sshp_monitor (
  input wire logic clk_i,   // System clock
  input wire logic nrst_i,  // Async reset, active low
  input wire logic sclk,    // Serial clock
  input wire logic cs_n,    // Select, active low
  input wire logic sdi,     // Master to slave data
  input wire logic sdo      // Slave to master data
);
  logic [16:0] bits;
  logic [7:0]  cmd;
  logic        sclk_q;
  logic        cs_q;
  wire         sclk_rise = sclk & ~sclk_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Count is held through the cycle of the select rise so frame checks see it
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      bits   <= 17'h0;
      cmd    <= 8'h00;
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
      if (cs_n && cs_q)
        bits <= 17'h0;
      else if (sclk_rise && !cs_n)
        bits <= bits + 17'h1;
      if (sclk_rise && !cs_n && bits < 17'h8)
        cmd <= {cmd[6:0], sdi};
    end
  sequence high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence low_phase;
    !sclk [*4];
  endsequence
  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  frame_open_a: assert property ($fell(cs_n) |-> !sclk [*2])
    else $error("frame opened with clock high");
  clock_high_a: assert property ($rose(sclk) |-> high_phase)
    else $error("clock high phase not four cycles");
  clock_low_a: assert property ($fell(sclk) && !cs_n |-> low_phase)
    else $error("clock low phase too short");
  sdi_hold_a: assert property ($rose(sclk) |-> $stable(sdi) [*4])
    else $error("input data moved while clock high");
  sdo_launch_a: assert property ($changed(sdo) && !cs_n && !$past(cs_n) |-> sclk)
    else $error("output data moved while clock low");
  whole_bytes_a: assert property ($rose(cs_n) |-> bits[2:0] == 3'h0 && bits >= 17'h8)
    else $error("frame not whole bytes");
  reg_frame_len_a: assert property ($rose(cs_n) && !cmd[7] |->
    bits == 17'h10 + 17'(8 * $countones(cmd[5:2])))
    else $error("register frame length wrong");
  queue_frame_len_a: assert property ($rose(cs_n) && cmd[7] |->
    bits >= 17'h10 && bits <= (cmd[6] ? 17'hc008 : 17'h18008))
    else $error("queue frame length out of range");
endmodule // sshp_monitor
`default_nettype wire
